// [rtl/dcarb_arbiter.sv]
/*
  DMA cycle arbiter: picks channel 0 DMA, channel 1 DMA or an instruction
  after every bus cycle.
  Assumes the sequencer pulses cycle_done at the end of each bus cycle and
  reports whether the finished instruction wrote a DMA register.
*/
// Summary of operation
// - One channel per DMA cycle, instructions suspended.
// - Choose next cycle after every completed cycle.
// - DMA register write forces another instruction.
// - Result 0, 1 or 2 by priority.
// - Burst channel always requests.
// - External demand uses interrupt flag 0/1.
// - Source UART buffer with receive flag requests.
// - Destination UART buffer with transmit flag requests.
// - Receive FIFO not empty requests, back to back.
// - Transmit FIFO needs flag and prior instruction.
// - Source match only in register space.
// - Destination match only in register space.
// - Lone alternate channel needs prior instruction.
// - Paired alternate channels take turns.
// - Instruction 1-4, DMA 1-2 machine cycles.
// - Hold modes qualify only requests with an external memory end.
// - Space select and increment pick memory space.
// - Demand and transfer mode bits pick mode.
// - Disabled channel never requests.
// - Requester DMA waits acknowledge, then completes.
`timescale 1ns/10ps
module dcarb_arbiter (
  input  wire logic                         mclk,
  input  wire logic                         reset_n,
  input  wire dcarb_pkg::dcarb_chan_cfg_type ch0_cfg,
  input  wire dcarb_pkg::dcarb_chan_cfg_type ch1_cfg,
  input  wire dcarb_pkg::dcarb_flags_type    flags,
  input  wire logic                         hold_arbiter_enable,
  input  wire logic                         hold_requester_enable,
  input  wire logic                         hold_ack_n_pin,
  input  wire logic                         hold_req_in_n_pin,
  input  wire logic                         cycle_done,
  input  wire logic                         instr_wrote_dma_reg,
  output logic [1:0]                        next_cycle_sel,
  output logic                              dma0_grant,
  output logic                              dma1_grant,
  output logic                              instr_grant,
  output logic                              decision_valid
);

  logic [1:0] ack_sync_reg;
  logic [1:0] hreq_sync_reg;
  logic       prev_instr_reg;
  logic       last_dma_ch1_reg;
  logic       force_instr_reg;
  logic       dma_locked_reg;
  logic [1:0] sel_next;
  logic [1:0] sel_reg;
  logic       decide_reg;
  logic [1:0] mode_req;
  logic [1:0] xram;
  dcarb_pkg::dcarb_chan_cfg_type cfg [2];

  assign cfg[0] = ch0_cfg;
  assign cfg[1] = ch1_cfg;

  // Hold pins are synchronised before use.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ack_sync_reg  <= 2'h3;
      hreq_sync_reg <= 2'h3;
    end else begin
      ack_sync_reg  <= {ack_sync_reg[0], hold_ack_n_pin};
      hreq_sync_reg <= {hreq_sync_reg[0], hold_req_in_n_pin};
    end
  end

  // Per-channel request logic.
  for (genvar n = 0; n < 2; n++) begin : g_chan
    logic src_sfr, dst_sfr, alt_n, alt_m, base, hh;
    always_comb begin
      src_sfr = cfg[n].source_space_sel && !cfg[n].source_increment;
      dst_sfr = cfg[n].dest_space_sel && !cfg[n].dest_increment;
      alt_n   = !cfg[n].demand_mode_bit && !cfg[n].transfer_mode_bit;
      alt_m   = !cfg[1-n].demand_mode_bit && !cfg[1-n].transfer_mode_bit;
      xram[n] = !cfg[n].source_space_sel || !cfg[n].dest_space_sel;
      base    = 1'b0;
      if (!cfg[n].demand_mode_bit && cfg[n].transfer_mode_bit) begin
        base = 1'b1;
      end else if (cfg[n].demand_mode_bit && cfg[n].transfer_mode_bit) begin
        base = (n == 0) ? flags.ext_int0_flag : flags.ext_int1_flag;
      end else if (cfg[n].demand_mode_bit) begin
        if (src_sfr && cfg[n].source_address == dcarb_pkg::DCARB_UART_BUF_ADDR && flags.uart_receive_flag) begin
          base = 1'b1;
        end else if (dst_sfr && cfg[n].dest_address == dcarb_pkg::DCARB_UART_BUF_ADDR
                     && flags.uart_transmit_flag) begin
          base = 1'b1;
        end else if (src_sfr && cfg[n].source_address == dcarb_pkg::DCARB_RX_FIFO_ADDR
                     && flags.rx_fifo_not_empty) begin
          base = 1'b1;
        end else if (dst_sfr && cfg[n].dest_address == dcarb_pkg::DCARB_TX_FIFO_ADDR
                     && flags.tx_fifo_flag && prev_instr_reg) begin
          base = 1'b1;
        end
      end else if (alt_n) begin
        if (!alt_m || !cfg[1-n].enable) begin
          base = prev_instr_reg;
        end else begin
          base = prev_instr_reg && (last_dma_ch1_reg == (n == 0));
        end
      end
      // Hold qualification applies only to external memory transfers.
      hh = 1'b1;
      if (hold_requester_enable && xram[n]) begin
        hh = !ack_sync_reg[1];
      end else if (hold_arbiter_enable && xram[n]) begin
        hh = hreq_sync_reg[1];
      end
      mode_req[n] = base && hh && cfg[n].enable;
    end
  end

  // Priority decision.
  always_comb begin
    if (force_instr_reg) begin
      sel_next = dcarb_pkg::DCARB_SEL_INSTR;
    end else if (mode_req[0]) begin
      sel_next = dcarb_pkg::DCARB_SEL_CH0;
    end else if (mode_req[1]) begin
      sel_next = dcarb_pkg::DCARB_SEL_CH1;
    end else begin
      sel_next = dcarb_pkg::DCARB_SEL_INSTR;
    end
  end

  // History of completed cycles; the sequencer times each cycle (1 to 4 machine cycles).
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prev_instr_reg   <= 1'b1;
      last_dma_ch1_reg <= 1'b1;
      force_instr_reg  <= 1'b0;
    end else if (cycle_done) begin
      prev_instr_reg  <= (sel_reg == dcarb_pkg::DCARB_SEL_INSTR);
      force_instr_reg <= (sel_reg == dcarb_pkg::DCARB_SEL_INSTR) && instr_wrote_dma_reg;
      if (sel_reg != dcarb_pkg::DCARB_SEL_INSTR) begin
        last_dma_ch1_reg <= (sel_reg == dcarb_pkg::DCARB_SEL_CH1);
      end
    end
  end

  // Once a DMA has started it is not re-judged by the hold input.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dma_locked_reg <= 1'b0;
    end else if (cycle_done) begin
      dma_locked_reg <= 1'b0;
    end else if (decide_reg && sel_reg != dcarb_pkg::DCARB_SEL_INSTR) begin
      dma_locked_reg <= 1'b1;
    end
  end

  // Decision is taken on the cycle after each completed cycle.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      decide_reg <= 1'b1;
    end else begin
      decide_reg <= cycle_done;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sel_reg        <= dcarb_pkg::DCARB_SEL_INSTR;
      next_cycle_sel <= dcarb_pkg::DCARB_SEL_INSTR;
      dma0_grant     <= 1'b0;
      dma1_grant     <= 1'b0;
      instr_grant    <= 1'b1;
      decision_valid <= 1'b0;
    end else begin
      decision_valid <= decide_reg;
      if (decide_reg && !dma_locked_reg) begin
        sel_reg        <= sel_next;
        next_cycle_sel <= sel_next;
        dma0_grant     <= (sel_next == dcarb_pkg::DCARB_SEL_CH0);
        dma1_grant     <= (sel_next == dcarb_pkg::DCARB_SEL_CH1);
        instr_grant    <= (sel_next == dcarb_pkg::DCARB_SEL_INSTR);
      end
    end
  end

endmodule : dcarb_arbiter

// [rtl/dcarb_pkg.sv]
/*
  Shared types and constants for the DMA cycle arbiter.
  Assumes a single clock domain and no register bus.
*/
package dcarb_pkg;

  // Arbitration result codes.
  localparam logic [1:0] DCARB_SEL_CH0   = 2'h0;
  localparam logic [1:0] DCARB_SEL_CH1   = 2'h1;
  localparam logic [1:0] DCARB_SEL_INSTR = 2'h2;

  // Serial buffer and FIFO addresses in special function register space.
  localparam logic [15:0] DCARB_UART_BUF_ADDR = 16'h0099;
  localparam logic [15:0] DCARB_RX_FIFO_ADDR  = 16'h00f4;
  localparam logic [15:0] DCARB_TX_FIFO_ADDR  = 16'h0085;

  // Machine cycles per bus cycle.
  localparam logic [2:0] DCARB_INSTR_MC_MAX = 3'h4;
  localparam logic [2:0] DCARB_DMA_MC_MAX   = 3'h2;

  // Controller states, Gray coded along the usual path.
  typedef enum logic [1:0] {
    DCARB_ST_DECIDE = 2'b00,
    DCARB_ST_INSTR  = 2'b01,
    DCARB_ST_DMA    = 2'b11
  } dcarb_state_type;

  // Per-channel control settings.
  typedef struct packed {
    logic        enable;
    logic        demand_mode_bit;
    logic        transfer_mode_bit;
    logic        source_space_sel;
    logic        source_increment;
    logic        dest_space_sel;
    logic        dest_increment;
    logic [15:0] source_address;
    logic [15:0] dest_address;
  } dcarb_chan_cfg_type;

  // Demand flags seen by the arbiter.
  typedef struct packed {
    logic ext_int0_flag;
    logic ext_int1_flag;
    logic uart_receive_flag;
    logic uart_transmit_flag;
    logic rx_fifo_not_empty;
    logic tx_fifo_flag;
  } dcarb_flags_type;

endpackage : dcarb_pkg

// [tb/dcarb_arbiter_bench.sv]
/* Self-checking bench for the DMA cycle arbiter.
   Assumes rtl/ package and arbiter, and the sequencer model. */
`timescale 1ns/10ps
module dcarb_arbiter_bench;
  logic                          mclk, cycle_done, dma0_grant, dma1_grant, instr_grant, decision_valid;
  logic                          reset_n = 1'b0, arb_en = 1'b0, req_en = 1'b0, ack_n = 1'b1;
  logic                          hreq_n = 1'b1, wrote = 1'b0, slow = 1'b0;
  logic [1:0]                    next_cycle_sel;
  dcarb_pkg::dcarb_chan_cfg_type ch0_cfg = '0, ch1_cfg = '0;
  dcarb_pkg::dcarb_flags_type    flags = '0;
  int                            bad_count = 0, n_compared = 0;
  dcarb_arbiter u_dut (.mclk, .reset_n, .ch0_cfg, .ch1_cfg, .flags, .hold_arbiter_enable(arb_en),
    .hold_requester_enable(req_en), .hold_ack_n_pin(ack_n), .hold_req_in_n_pin(hreq_n), .cycle_done,
    .instr_wrote_dma_reg(wrote), .next_cycle_sel, .dma0_grant, .dma1_grant, .instr_grant, .decision_valid);
  dcarb_seq u_seq (.mclk, .reset_n, .decision_valid, .instr_grant, .slow, .cycle_done);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic report_and_stop();
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  task automatic next_dec();
    int w = 0;
    do begin
      @(posedge mclk);
      w++;
    end while (decision_valid !== 1'b1 && w < 40);
    if (decision_valid !== 1'b1) begin
      bad_count++;
      $display("BAD decision_valid expected 1 seen %b", decision_valid);
    end
  endtask : next_dec
  task automatic expect4(input string nm, input logic [7:0] e);
    for (int i = 3; i >= 0; i--) begin
      next_dec();
      n_compared++;
      if (next_cycle_sel !== e[2*i+:2]) begin
        bad_count++;
        $display("BAD %s expected %h seen %h", nm, e[2*i+:2], next_cycle_sel);
      end
    end
    $display("test %s ends", nm);
  endtask : expect4
  task automatic run(input string nm, input logic [6:0] b0, b1, input logic [15:0] a,
                     input logic [5:0] f, input int sk, input logic [7:0] e);
    ch0_cfg <= {b0, a, a};
    ch1_cfg <= {b1, a, a};
    flags   <= f;
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (sk) next_dec();
    expect4(nm, e);
  endtask : run
  initial begin
    @(posedge mclk);
    run("burst1", 7'h00, 7'h50, 16'h0000, 6'h00, 0, 8'h55);
    run("burst2", 7'h50, 7'h50, 16'h0000, 6'h00, 0, 8'h00);
    slow <= 1'b1;
    run("alt2", 7'h40, 7'h40, 16'h0000, 6'h00, 0, 8'h26);
    run("alt1", 7'h00, 7'h40, 16'h0000, 6'h00, 0, 8'h66);
    run("txfifo", 7'h6e, 7'h00, 16'h0085, 6'h01, 0, 8'h22);
    slow <= 1'b0;
    run("rxfifo", 7'h00, 7'h6b, 16'h00f4, 6'h02, 0, 8'h55);
    run("uarttx", 7'h6f, 7'h62, 16'h0099, 6'h0c, 0, 8'h55);
    run("uartrx", 7'h68, 7'h00, 16'h0099, 6'h08, 0, 8'h00);
    run("ext", 7'h70, 7'h70, 16'h0000, 6'h10, 0, 8'h55);
    wrote <= 1'b1;
    run("wrhold", 7'h10, 7'h00, 16'h0000, 6'h00, 0, 8'haa);
    ch0_cfg.enable <= 1'b1;
    expect4("wrblock", 8'haa);
    wrote <= 1'b0;
    next_dec();
    next_dec();
    expect4("wrfree", 8'h00);
    req_en <= 1'b1;
    run("reqwait", 7'h50, 7'h00, 16'h0000, 6'h00, 2, 8'haa);
    ack_n <= 1'b0;
    next_dec();
    next_dec();
    expect4("reqgo", 8'h00);
    req_en <= 1'b0;
    arb_en <= 1'b1;
    hreq_n <= 1'b0;
    run("arbblock", 7'h50, 7'h00, 16'h0000, 6'h00, 2, 8'haa);
    report_and_stop();
  end
  initial begin
    #20000;
    bad_count++;
    report_and_stop();
  end
endmodule : dcarb_arbiter_bench

// [tb/dcarb_checker.sv]
/* Port assertions for the DMA cycle arbiter.
   Assumes one clock domain and the bind below. */
`timescale 1ns/10ps
module dcarb_checker (
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic       cycle_done,
  input wire logic       instr_wrote_dma_reg,
  input wire logic [1:0] next_cycle_sel,
  input wire logic       dma0_grant,
  input wire logic       dma1_grant,
  input wire logic       instr_grant,
  input wire logic       decision_valid
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  one_bus_a: assert property ($onehot({dma0_grant, dma1_grant, instr_grant}))
    else $error("Grants not one-hot.");
  sel_code_a: assert property (
    dma0_grant == (next_cycle_sel == 2'h0) && dma1_grant == (next_cycle_sel == 2'h1))
    else $error("Code and grants differ.");
  answer_time_a: assert property (cycle_done |-> ##2 decision_valid)
    else $error("No decision after cycle end.");
  valid_pulse_a: assert property (decision_valid |=> !decision_valid)
    else $error("Decision pulse too long.");
  sel_holds_a: assert property (!decision_valid |-> $stable(next_cycle_sel))
    else $error("Selection moved alone.");
  reset_start_a: assert property ($rose(reset_n) |-> ##1 decision_valid)
    else $error("No first decision.");
  decision_cause_a: assert property (
    decision_valid |-> $past(cycle_done, 2) || !$past(reset_n, 2))
    else $error("Decision without cause.");
  reg_write_a: assert property (
    cycle_done && instr_grant && instr_wrote_dma_reg |-> ##3 instr_grant)
    else $error("DMA after register write.");
endmodule : dcarb_checker
bind dcarb_arbiter dcarb_checker u_chk (.mclk, .reset_n, .cycle_done, .instr_wrote_dma_reg,
  .next_cycle_sel, .dma0_grant, .dma1_grant, .instr_grant, .decision_valid);

// [tb/dcarb_seq.sv]
/* Sequencer model: runs each granted bus cycle, then pulses cycle_done.
   Assumes the arbiter's grants and decision pulse. */
`timescale 1ns/10ps
module dcarb_seq (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic decision_valid,
  input  wire logic instr_grant,
  input  wire logic slow,
  output logic      cycle_done
);
  logic [2:0] cnt_reg;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg    <= 3'h0;
      cycle_done <= 1'b0;
    end else begin
      cycle_done <= (cnt_reg == 3'h1);
      if (decision_valid) begin
        cnt_reg <= !slow ? 3'h1 : instr_grant ? 3'h4 : 3'h2;
      end else if (cnt_reg != 3'h0) begin
        cnt_reg <= cnt_reg - 3'h1;
      end
    end
  end
endmodule : dcarb_seq
